// ### inc/pin_mux_pkg.sv
package pin_mux_pkg;
	// ----------------------------------------------------------------
	// register map
	// ----------------------------------------------------------------
	// word indexes: each byte address is four times its index
	localparam logic [15:0] pin0_function_select_off = 16'ha050;
	localparam logic [15:0] pin1_function_select_off = 16'ha051;
	localparam logic [15:0] pin2_function_select_off = 16'ha052;
	localparam int num_pins = 3;
	localparam logic [7:0] cfg_reset = 8'h00;
	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int general_io_enable_bit = 0;
	localparam int pin_irq_a_route_bit = 1;
	localparam int pin_irq_b_route_bit = 2;
	localparam int spi_select_pin_enable_bit = 3;
	localparam int ccp_pin_enable_bit = 4;
	localparam int touch_enable_bit = 7;
	// writable bits per pin
	localparam logic [7:0] pin0_write_mask = 8'h9f;
	localparam logic [7:0] pin1_write_mask = 8'h97;
	localparam logic [7:0] pin2_write_mask = 8'h87;
	// ----------------------------------------------------------------
	// pad input synchroniser
	// ----------------------------------------------------------------
	localparam int sync_stages = 3;
endpackage

// ### rtl/cfg_reg.sv
`timescale 1ns/1ps
module cfg_reg #(
	parameter logic [7:0] write_mask = 8'hff,
	parameter logic [7:0] reset_value = 8'h00
) (
	input wire logic pclk, // system clock
	input wire logic presetn, // async reset, active low
	input wire logic wr_en, // write strobe
	input wire logic [7:0] wr_data, // write data
	output logic [7:0] value // register contents
);
	typedef struct packed {
		logic [7:0] val;
	} state_t;
	state_t s_q, s_d;

	always_comb begin
		s_d = s_q;
		if (wr_en) begin
			s_d.val = wr_data & write_mask;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_q <= '{val: reset_value};
		end else begin
			s_q <= s_d;
		end
	end

	assign value = s_q.val;
endmodule // cfg_reg

// ### rtl/pin_sync.sv
`timescale 1ns/1ps
module pin_sync (
	input wire logic pclk, // system clock
	input wire logic presetn, // async reset, active low
	input wire logic pin_in, // raw pad level
	output logic level // filtered level
);
	typedef struct packed {
		logic [2:0] sh;
		logic lvl;
	} state_t;
	state_t s_q, s_d;

	always_comb begin
		s_d = s_q;
		s_d.sh = {s_q.sh[1:0], pin_in};
		// accept a change once stages two and three agree
		if (s_q.sh[1] == s_q.sh[2]) begin
			s_d.lvl = s_q.sh[2];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign level = s_q.lvl;
endmodule // pin_sync

// ### rtl/port0_pin_function_select.sv
// Behaviour
// - each of the three pins has its own function configuration register
// - registers read and write, and reset to zero
// - bit 0 connects the pin to general-purpose I/O
// - general I/O stays disconnected after reset until software sets bit 0
// - bit 1 routes the pin input into interrupt line a
// - bit 2 routes the pin input into interrupt line b
// - several pins on one line are ORed together
// - one pin may feed both interrupt lines at once
// - pin 0 bit 3 makes it the SPI slave-select input
// - pin 0 bit 4 makes it capture/compare channel 4 I/O
// - pin 1 bit 4 makes it capture/compare channel 5 I/O
// - bit 7 enables touch controller two on pin 0, touch inputs on pins 1, 2
`timescale 1ns/1ps
module port0_pin_function_select
	import pin_mux_pkg::*;
(
	input wire logic pclk, // system clock
	input wire logic presetn, // async reset, active low
	// ----------------------------------------------------------------
	// apb slave
	// ----------------------------------------------------------------
	input wire logic psel, // select
	input wire logic penable, // access phase
	input wire logic pwrite, // write
	input wire logic [17:0] paddr, // byte address
	input wire logic [31:0] pwdata, // write data
	input wire logic [3:0] pstrb, // byte strobes
	output logic [31:0] prdata, // read data
	output logic pready, // ready
	output logic pslverr, // error on unmapped address
	// ----------------------------------------------------------------
	// pads
	// ----------------------------------------------------------------
	input wire logic [2:0] pad_in, // pad input levels
	output logic [2:0] pad_out, // pad output levels
	output logic [2:0] pad_oe, // pad output enable, high drives
	// ----------------------------------------------------------------
	// general-purpose I/O logic
	// ----------------------------------------------------------------
	input wire logic [2:0] gpio_out, // gpio output data
	input wire logic [2:0] gpio_oe, // gpio output enable
	output logic [2:0] gpio_in, // pin level to gpio, 0 when off
	// ----------------------------------------------------------------
	// pin interrupt lines
	// ----------------------------------------------------------------
	output logic pin_irq_a, // or of routed pin inputs
	output logic pin_irq_b, // or of routed pin inputs
	// ----------------------------------------------------------------
	// peripherals
	// ----------------------------------------------------------------
	output logic spi_select_n, // spi slave select, 1 when unrouted
	input wire logic capture_compare_ch4_out, // ch4 output
	input wire logic capture_compare_ch4_oe, // ch4 output enable
	output logic capture_compare_ch4_in, // ch4 capture input
	input wire logic capture_compare_ch5_out, // ch5 output
	input wire logic capture_compare_ch5_oe, // ch5 output enable
	output logic capture_compare_ch5_in, // ch5 capture input
	output logic touch_ctrl_two_enable, // touch controller two on pin 0
	output logic touch_input_one_enable, // touch input on pin 1
	output logic touch_input_two_enable // touch input on pin 2
);
	import pin_mux_pkg::*;

	// ----------------------------------------------------------------
	// register file
	// ----------------------------------------------------------------
	logic [7:0] cfg [num_pins];
	logic [num_pins-1:0] hit;
	logic [2:0] lvl;
	logic wr_go;

	// write lands on the completing edge, where pready is sampled high
	assign wr_go = psel & penable & pwrite & pstrb[0] & pready;
	assign hit[0] = paddr == {pin0_function_select_off, 2'b00};
	assign hit[1] = paddr == {pin1_function_select_off, 2'b00};
	assign hit[2] = paddr == {pin2_function_select_off, 2'b00};

	cfg_reg #(.write_mask(pin0_write_mask), .reset_value(cfg_reset)) u_cfg0 (
		.pclk(pclk),
		.presetn(presetn),
		.wr_en(wr_go & hit[0]),
		.wr_data(pwdata[7:0]),
		.value(cfg[0])
	);
	cfg_reg #(.write_mask(pin1_write_mask), .reset_value(cfg_reset)) u_cfg1 (
		.pclk(pclk),
		.presetn(presetn),
		.wr_en(wr_go & hit[1]),
		.wr_data(pwdata[7:0]),
		.value(cfg[1])
	);
	cfg_reg #(.write_mask(pin2_write_mask), .reset_value(cfg_reset)) u_cfg2 (
		.pclk(pclk),
		.presetn(presetn),
		.wr_en(wr_go & hit[2]),
		.wr_data(pwdata[7:0]),
		.value(cfg[2])
	);

	// ----------------------------------------------------------------
	// pad input synchronisers
	// ----------------------------------------------------------------
	for (genvar i = 0; i < num_pins; i++) begin : g_sync
		pin_sync u_sync (
			.pclk(pclk),
			.presetn(presetn),
			.pin_in(pad_in[i]),
			.level(lvl[i])
		);
	end

	// ----------------------------------------------------------------
	// registered outputs
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [31:0] rdata;
		logic rdy;
		logic err;
		logic [2:0] pout;
		logic [2:0] poe;
		logic [2:0] gin;
		logic irq_a;
		logic irq_b;
		logic ssn;
		logic cc4_in;
		logic cc5_in;
		logic tk0;
		logic tk1;
		logic tk2;
	} state_t;
	state_t s_q, s_d;

	always_comb begin
		s_d = s_q;
		// apb: one wait state, answer in the cycle after the access phase opens
		s_d.rdy = psel & penable & ~s_q.rdy;
		s_d.err = psel & penable & ~s_q.rdy & ~(|hit);
		s_d.rdata = 32'h0000_0000;
		if (psel & penable & ~s_q.rdy & ~pwrite) begin
			for (int i = 0; i < num_pins; i++) begin
				if (hit[i]) begin
					s_d.rdata = {24'h00_0000, cfg[i]};
				end
			end
		end
		// general I/O path only when enabled
		for (int i = 0; i < num_pins; i++) begin
			s_d.gin[i] = cfg[i][general_io_enable_bit] & lvl[i];
			s_d.pout[i] = gpio_out[i];
			s_d.poe[i] = cfg[i][general_io_enable_bit] & gpio_oe[i];
		end
		// capture/compare take the pad over from general I/O
		if (cfg[0][ccp_pin_enable_bit]) begin
			s_d.pout[0] = capture_compare_ch4_out;
			s_d.poe[0] = capture_compare_ch4_oe;
		end
		if (cfg[1][ccp_pin_enable_bit]) begin
			s_d.pout[1] = capture_compare_ch5_out;
			s_d.poe[1] = capture_compare_ch5_oe;
		end
		s_d.cc4_in = cfg[0][ccp_pin_enable_bit] & lvl[0];
		s_d.cc5_in = cfg[1][ccp_pin_enable_bit] & lvl[1];
		s_d.ssn = cfg[0][spi_select_pin_enable_bit] ? lvl[0] : 1'b1;
		// interrupt lines combine every routed pin
		s_d.irq_a = 1'b0;
		s_d.irq_b = 1'b0;
		for (int i = 0; i < num_pins; i++) begin
			s_d.irq_a = s_d.irq_a | (cfg[i][pin_irq_a_route_bit] & lvl[i]);
			s_d.irq_b = s_d.irq_b | (cfg[i][pin_irq_b_route_bit] & lvl[i]);
		end
		s_d.tk0 = cfg[0][touch_enable_bit];
		s_d.tk1 = cfg[1][touch_enable_bit];
		s_d.tk2 = cfg[2][touch_enable_bit];
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_q <= '0;
			s_q.ssn <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end

	assign prdata = s_q.rdata;
	assign pready = s_q.rdy;
	assign pslverr = s_q.err;
	assign pad_out = s_q.pout;
	assign pad_oe = s_q.poe;
	assign gpio_in = s_q.gin;
	assign pin_irq_a = s_q.irq_a;
	assign pin_irq_b = s_q.irq_b;
	assign spi_select_n = s_q.ssn;
	assign capture_compare_ch4_in = s_q.cc4_in;
	assign capture_compare_ch5_in = s_q.cc5_in;
	assign touch_ctrl_two_enable = s_q.tk0;
	assign touch_input_one_enable = s_q.tk1;
	assign touch_input_two_enable = s_q.tk2;
endmodule // port0_pin_function_select

// ### verif/pad_side_model.sv
`timescale 1ns/1ps
module pad_side_model (
	input wire logic [2:0] ext_level, // board level
	input wire logic [2:0] pad_out, // pad data
	input wire logic [2:0] pad_oe, // pad enable
	output logic [2:0] pad_in // wire level
);
	// the pad follows the chip wherever it drives, else the board
	assign pad_in = (pad_oe & pad_out) | (~pad_oe & ext_level);
endmodule // pad_side_model

// ### verif/pin_mux_chk.sv
`timescale 1ns/1ps
module pin_mux_chk (
	input wire logic pclk, // clock
	input wire logic presetn, // reset
	input wire logic psel, // select
	input wire logic penable, // access
	input wire logic pwrite, // write
	input wire logic [17:0] paddr, // address
	input wire logic [31:0] prdata, // data
	input wire logic pready, // ready
	input wire logic pslverr, // error
	input wire logic [2:0] pad_in, // pads
	input wire logic [2:0] gpio_in, // gpio
	input wire logic pin_irq_a, // irq a
	input wire logic pin_irq_b, // irq b
	input wire logic spi_select_n, // select
	input wire logic touch_ctrl_two_enable // touch
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence s_take; psel && $rose(penable); endsequence
	sequence s_low; pad_in == 3'h0 [*8]; endsequence
	AST_ANSWER: assert property (s_take |=> pready) else $error("no ready");
	AST_PULSE: assert property (pready |=> !pready) else $error("ready long");
	AST_ERR: assert property (pslverr |-> pready && (paddr[1:0] != 2'h0 ||
		paddr[17:2] > 16'ha052 || paddr[17:2] < 16'ha050)) else $error("bad error");
	AST_UPPER: assert property (pready |-> prdata[31:8] == 24'h0) else $error("upper");
	AST_RSV0: assert property (pready && paddr == 18'h28140 |-> prdata[6:5] == 2'h0)
		else $error("rsv0");
	AST_RSV2: assert property (pready && paddr == 18'h28148 |-> prdata[6:3] == 4'h0)
		else $error("rsv2");
	AST_TKRD: assert property (pready && !pwrite && paddr == 18'h28140 |->
		prdata[7] == touch_ctrl_two_enable) else $error("touch");
	AST_TKCHG: assert property ($changed(touch_ctrl_two_enable) |->
		$past(psel && pwrite) || $past(psel && pwrite, 2)) else $error("touch chg");
	AST_IDLE: assert property (s_low |-> !pin_irq_a && !pin_irq_b && gpio_in == 3'h0)
		else $error("idle");
	AST_SPIHI: assert property (pad_in[0] [*8] |-> spi_select_n) else $error("spi");
endmodule // pin_mux_chk
bind port0_pin_function_select pin_mux_chk u_chk (.pclk, .presetn, .psel, .penable, .pwrite,
	.paddr, .prdata, .pready, .pslverr, .pad_in, .gpio_in, .pin_irq_a, .pin_irq_b,
	.spi_select_n, .touch_ctrl_two_enable);

// ### verif/port0_pin_function_select_tb_top.sv
`timescale 1ns/1ps
module port0_pin_function_select_tb_top;
	import pin_mux_pkg::*;
	typedef struct {logic [17:0] a; logic [7:0] d; logic [7:0] x; logic e;} row_t;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, ia, ib, ssn, c4i, c5i;
	logic c4o, c4e, c5o, c5e, tk0, tk1, tk2, e;
	logic [17:0] paddr;
	logic [31:0] pwdata, prdata, r;
	logic [3:0] pstrb;
	logic [2:0] pin, pout, poe, go, goe, gi, ext;
	int fail_count, num_checks;
	row_t rows [6] = '{'{18'h28140, 8'hff, 8'h9f, 1'b0}, '{18'h28144, 8'hff, 8'h97, 1'b0},
		'{18'h28148, 8'hff, 8'h87, 1'b0}, '{18'h2814c, 8'hff, 8'h00, 1'b1},
		'{18'h2813c, 8'hff, 8'h00, 1'b1}, '{18'h28140, 8'h60, 8'h00, 1'b0}};
	port0_pin_function_select u_port0_pin_function_select (.pclk, .presetn, .psel, .penable,
		.pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .pad_in(pin), .pad_out(pout),
		.pad_oe(poe), .gpio_out(go), .gpio_oe(goe), .gpio_in(gi), .pin_irq_a(ia), .pin_irq_b(ib),
		.spi_select_n(ssn), .capture_compare_ch4_out(c4o), .capture_compare_ch4_oe(c4e),
		.capture_compare_ch4_in(c4i), .capture_compare_ch5_out(c5o), .capture_compare_ch5_oe(c5e),
		.capture_compare_ch5_in(c5i), .touch_ctrl_two_enable(tk0), .touch_input_one_enable(tk1),
		.touch_input_two_enable(tk2));
	pad_side_model u_pad_side_model (.ext_level(ext), .pad_out(pout), .pad_oe(poe), .pad_in(pin));
	task automatic chk(input logic [32:0] s, input logic [32:0] x);
		num_checks++;
		if (s !== x) begin
			fail_count++;
			$display("[FAIL] %0t seen %h want %h", $time, s, x);
		end
	endtask
	task automatic xfer(input logic w, input logic [17:0] a, input logic [7:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h0, d};
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1 && ++n < 20);
		if (n == 20) fail_count++;
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic cfg(input logic [7:0] a0, input logic [7:0] a1, input logic [7:0] a2);
		xfer(1'b1, {pin0_function_select_off, 2'b00}, a0);
		xfer(1'b1, {pin1_function_select_off, 2'b00}, a1);
		xfer(1'b1, {pin2_function_select_off, 2'b00}, a2);
	endtask
	// drive the board level, let the synchroniser settle, compare irq and gpio
	task automatic pads(input logic [2:0] v, input logic [4:0] x);
		ext <= v;
		repeat (8) @(posedge pclk);
		chk({ia, ib, gi}, x);
	endtask
	task automatic report_and_stop();
		if (fail_count == 0 && num_checks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	initial begin
		#20000;
		fail_count++;
		report_and_stop();
	end
	initial begin
		{presetn, psel, penable, pwrite, c4o, c4e, c5o, c5e, paddr, pwdata, go, goe} = '0;
		pstrb = 4'h1;
		ext = 3'h7;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		pads(3'h7, 5'h00);
		chk(ssn, 1'b1);
		for (int i = 0; i < 3; i++) begin
			xfer(1'b0, {16'ha050 + 16'(i), 2'b00}, 8'h00);
			chk(r, 0);
		end
		foreach (rows[i]) begin
			xfer(1'b1, rows[i].a, rows[i].d);
			chk(e, rows[i].e);
			xfer(1'b0, rows[i].a, 8'h00);
			chk({e, r}, {rows[i].e, 24'h0, rows[i].x});
		end
		cfg(8'h07, 8'h02, 8'h04);
		pads(3'h1, 5'h19);
		pads(3'h2, 5'h10);
		pads(3'h4, 5'h08);
		pads(3'h6, 5'h18);
		cfg(8'h98, 8'h90, 8'h80);
		goe <= 3'h7;
		pads(3'h0, 5'h00);
		chk({ssn, c4i, c5i, tk0, tk1, tk2}, 6'h07);
		pads(3'h3, 5'h00);
		chk({ssn, c4i, c5i}, 3'h7);
		{c4e, c4o, c5e, c5o} <= 4'hb;
		pads(3'h3, 5'h00);
		chk({poe, pout[1:0], ssn}, 6'h1c);
		// general I/O drives pins 1 and 2, capture/compare keeps pin 0
		cfg(8'h11, 8'h01, 8'h01);
		go <= 3'h6;
		{c4e, c4o} <= 2'b11;
		pads(3'h0, 5'h07);
		chk({poe, pout, c4i, ssn}, 8'hff);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		xfer(1'b0, {pin0_function_select_off, 2'b00}, 8'h00);
		chk({r[7:0], tk0}, 9'h0);
		chk({poe, gi, ssn}, 7'h01);
		report_and_stop();
	end
endmodule // port0_pin_function_select_tb_top
